/* File: rtl/negate_invert_pkg.sv */
/*
 * Package for the negate/invert datapath slice: instruction field layout,
 * opcode patterns, shift and operation enumerations and the carrier structs.
 * Assumes nothing of its surroundings.
 */
package negate_invert_pkg;

    localparam int XLEN = 64;
    localparam int HALF_XLEN = 32;
    localparam int INSN_W = 32;

    // Instruction field positions.
    localparam int WSEL_BIT = 31;
    localparam int OPC_HI = 30;
    localparam int OPC_LO = 24;
    localparam int SHT_HI = 23;
    localparam int SHT_LO = 22;
    localparam int NOT_BIT = 21;
    localparam int SRC2_HI = 20;
    localparam int SRC2_LO = 16;
    localparam int AMT_HI = 15;
    localparam int AMT_LO = 10;
    localparam int SRC1_HI = 9;
    localparam int SRC1_LO = 5;
    localparam int DST_HI = 4;
    localparam int DST_LO = 0;
    localparam int AMT_TOP = 15;
    localparam int CARRY_MID_HI = 15;
    localparam int CARRY_MID_LO = 10;

    // Opcode patterns of bits 30:24 plus the extra bits that pin each form.
    localparam logic [6:0] OPC_OR_NOT = 7'h2A;
    localparam logic [6:0] OPC_SUB = 7'h4B;
    localparam logic [6:0] OPC_SUB_FLAGGED = 7'h6B;
    localparam logic [6:0] OPC_BORROW = 7'h5A;
    localparam logic [6:0] OPC_BORROW_FLAGGED = 7'h7A;
    localparam logic [1:0] BORROW_SHT_BITS = 2'h0;
    localparam logic [5:0] BORROW_MID_BITS = 6'h00;
    localparam logic [4:0] ZERO_REG_IDX = 5'h1F;

    localparam logic [1:0] SHT_LOGICAL_LEFT = 2'h0;
    localparam logic [1:0] SHT_LOGICAL_RIGHT = 2'h1;
    localparam logic [1:0] SHT_ARITH_RIGHT = 2'h2;
    localparam logic [1:0] SHT_ROTATE_RIGHT = 2'h3;

    typedef enum logic [1:0] {
        logical_left,
        logical_right,
        arith_right,
        rotate_right
    } shift_kind_t;

    typedef enum logic [2:0] {
        op_none,
        bitwise_invert_alias,
        twos_complement_alias,
        flagged_complement_alias,
        carry_complement_alias,
        carry_complement_flagged_alias
    } alias_kind_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cond_flags_t;

    typedef struct packed {
        logic valid;
        logic [INSN_W-1:0] insn;
        logic [XLEN-1:0] second_src_value;
        cond_flags_t flags;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic undefined;
        logic [4:0] dst;
        logic [XLEN-1:0] value;
        logic flags_we;
        cond_flags_t flags;
    } result_t;

endpackage : negate_invert_pkg

/* File: rtl/operand_shifter.sv */
/*
 * Shifter for the second operand: logical left, logical right, arithmetic
 * right and rotate right at 32-bit or 64-bit width.
 * Assumes a valid amount; the caller screens illegal encodings.
 */
`timescale 1ns/1ps
module operand_shifter
    import negate_invert_pkg::*;
#(
    parameter int W = XLEN
) (
    input wire logic [W-1:0] value_i,
    input wire shift_kind_t kind_i,
    input wire logic [5:0] amount_i,
    input wire logic wide_i,
    output logic [W-1:0] shifted_o
);
    logic [HALF_XLEN-1:0] narrow;
    logic [HALF_XLEN-1:0] narrow_res;
    logic [4:0] namt;
    logic [W-1:0] wide_res;
    logic [2*W-1:0] rot_wide;
    logic [2*HALF_XLEN-1:0] rot_narrow;

    // Right shifts inject at the top of the selected width, so the narrow
    // view gets its own shifter instead of masking the wide one.
    always_comb begin
        narrow = value_i[HALF_XLEN-1:0];
        namt = amount_i[4:0];
        rot_narrow = {narrow, narrow} >> namt;
        rot_wide = {value_i, value_i} >> amount_i;
        case (kind_i)
            logical_right: begin
                narrow_res = narrow >> namt;
                wide_res = value_i >> amount_i;
            end
            arith_right: begin
                narrow_res = HALF_XLEN'($signed(narrow) >>> namt);
                wide_res = W'($signed(value_i) >>> amount_i);
            end
            rotate_right: begin
                narrow_res = rot_narrow[HALF_XLEN-1:0];
                wide_res = rot_wide[W-1:0];
            end
            default: begin
                narrow_res = narrow << namt;
                wide_res = value_i << amount_i;
            end
        endcase
        shifted_o = wide_i ? wide_res : {{(W-HALF_XLEN){1'b0}}, narrow_res};
    end

endmodule : operand_shifter

/* File: rtl/negate_invert_unit.sv */
/*
 * Decode and execute stage for the invert and negate alias forms.
 * Takes one instruction per cycle with its second source value and the
 * current flags; answers one cycle later with a registered result.
 * Assumes the pipeline reads the register file and retires the result.
 */
//
// Contract
// - Invert alias writes one's complement of the shifted second source.
// - Invert alias runs as or-not with zero register first operand.
// - Invert shift codes 00..11: left, right, arith right, rotate.
// - 32-bit shift amount from six-bit field, legal 0 to 31.
// - 64-bit shift amount from six-bit field, legal 0 to 63.
// - Width bit clear selects 32-bit views; set selects 64-bit.
// - Negate alias writes two's complement of shifted operand, flags kept.
// - Negate alias is shifted subtraction from the zero register.
// - Negate shift codes 00, 01, 10: left, right, arith right.
// - Negate shift code 11 is reserved; never rotate.
// - Flagged negate writes result and updates N, Z, C, V.
// - Flagged negate is flag-setting subtraction from zero register.
// - Carry negate writes minus (source plus inverted carry), flags kept.
// - Carry negate is subtract-with-borrow from zero, no shift.
// - Flagged carry negate gives same result and updates flags.
// - Flagged carry negate is flag-setting subtract-with-borrow from zero.
// - Latency is fixed, independent of data and flags.
// - Exception response is independent of data and flags.
// - 32-bit invert with amount top bit set is undefined.
// - Or-not complements shifted operand then ORs first operand.
`timescale 1ns/1ps
module negate_invert_unit
    import negate_invert_pkg::*;
#(
    parameter int W = XLEN
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire issue_t issue_i,
    input wire logic flush_i,
    output result_t result_o,
    output alias_kind_t kind_o
);
    typedef struct packed {
        result_t res;
        alias_kind_t kind;
    } state_t;

    state_t state;
    state_t next_state;

    logic [INSN_W-1:0] insn;
    logic wide;
    logic [6:0] opc;
    logic [1:0] sht;
    logic [5:0] amt;
    logic [4:0] dst;
    logic first_is_zero;
    alias_kind_t kind;
    shift_kind_t sh_kind;
    logic [5:0] sh_amt;
    logic [W-1:0] src2;
    logic [W-1:0] shifted;
    logic [W-1:0] zero_reg;
    logic [W-1:0] operand2;
    logic carry_in;
    logic [W:0] sum_wide;
    logic [HALF_XLEN:0] sum_narrow;
    logic [W-1:0] result;
    cond_flags_t new_flags;
    logic undef;

    always_comb begin
        insn = issue_i.insn;
        wide = insn[WSEL_BIT];
        opc = insn[OPC_HI:OPC_LO];
        sht = insn[SHT_HI:SHT_LO];
        amt = insn[AMT_HI:AMT_LO];
        dst = insn[DST_HI:DST_LO];
        first_is_zero = insn[SRC1_HI:SRC1_LO] == ZERO_REG_IDX;
        kind = op_none;
        if (first_is_zero) begin
            if (opc == OPC_OR_NOT && insn[NOT_BIT]) begin
                kind = bitwise_invert_alias;
            end else if (opc == OPC_SUB && !insn[NOT_BIT]) begin
                kind = twos_complement_alias;
            end else if (opc == OPC_SUB_FLAGGED && !insn[NOT_BIT] && dst != ZERO_REG_IDX) begin
                kind = flagged_complement_alias;
            end else if (sht == BORROW_SHT_BITS && !insn[NOT_BIT]
                         && insn[CARRY_MID_HI:CARRY_MID_LO] == BORROW_MID_BITS) begin
                if (opc == OPC_BORROW) begin
                    kind = carry_complement_alias;
                end else if (opc == OPC_BORROW_FLAGGED) begin
                    kind = carry_complement_flagged_alias;
                end
            end
        end
    end

    always_comb begin
        case (sht)
            SHT_LOGICAL_RIGHT: sh_kind = logical_right;
            SHT_ARITH_RIGHT: sh_kind = arith_right;
            SHT_ROTATE_RIGHT: sh_kind = rotate_right;
            default: sh_kind = logical_left;
        endcase
        // The carry forms have no shift field; their amount is forced to zero.
        if (kind == carry_complement_alias || kind == carry_complement_flagged_alias) begin
            sh_amt = '0;
        end else begin
            sh_amt = amt;
        end
        // A 32-bit amount of 32 or more and the reserved code on the
        // subtract forms are undefined encodings, not executed.
        undef = 1'b0;
        if (!wide && amt[AMT_TOP-AMT_LO] && kind != op_none
            && kind != carry_complement_alias
            && kind != carry_complement_flagged_alias) begin
            undef = 1'b1;
        end
        if ((kind == twos_complement_alias || kind == flagged_complement_alias)
            && sht == SHT_ROTATE_RIGHT) begin
            undef = 1'b1;
        end
    end

    operand_shifter #(
        .W(W)
    ) u_shifter (
        .value_i(issue_i.second_src_value),
        .kind_i(sh_kind),
        .amount_i(sh_amt),
        .wide_i(wide),
        .shifted_o(shifted)
    );

    // Every alias is computed in one combinational pass (or-not for invert, the adder for
    // the rest), so the answer arrives after a fixed one-cycle latency for any data or flags.
    always_comb begin
        src2 = issue_i.second_src_value;
        zero_reg = '0;
        operand2 = shifted;
        if (!wide) begin
            src2 = {{(W-HALF_XLEN){1'b0}}, issue_i.second_src_value[HALF_XLEN-1:0]};
        end
        carry_in = 1'b1;
        if (kind == carry_complement_alias || kind == carry_complement_flagged_alias) begin
            operand2 = src2;
            carry_in = issue_i.flags.c;
        end
        // Zero plus NOT(operand) plus carry: subtraction and subtract-with-borrow.
        sum_wide = {1'b0, zero_reg} + {1'b0, ~operand2} + {{W{1'b0}}, carry_in};
        sum_narrow = {1'b0, zero_reg[HALF_XLEN-1:0]} + {1'b0, ~operand2[HALF_XLEN-1:0]}
                     + {{HALF_XLEN{1'b0}}, carry_in};
        new_flags = issue_i.flags;
        if (kind == bitwise_invert_alias) begin
            result = zero_reg | ~shifted;
            if (!wide) begin
                result = {{(W-HALF_XLEN){1'b0}}, result[HALF_XLEN-1:0]};
            end
        end else if (wide) begin
            result = sum_wide[W-1:0];
            new_flags.n = sum_wide[W-1];
            new_flags.z = sum_wide[W-1:0] == '0;
            new_flags.c = sum_wide[W];
            // Overflow of 0 - op needs a negative operand and a negative result.
            new_flags.v = operand2[W-1] & sum_wide[W-1];
        end else begin
            result = {{(W-HALF_XLEN){1'b0}}, sum_narrow[HALF_XLEN-1:0]};
            new_flags.n = sum_narrow[HALF_XLEN-1];
            new_flags.z = sum_narrow[HALF_XLEN-1:0] == '0;
            new_flags.c = sum_narrow[HALF_XLEN];
            new_flags.v = operand2[HALF_XLEN-1] & sum_narrow[HALF_XLEN-1];
        end
        // Only the flag-setting forms replace the flags; the rest pass them on.
        if (kind != flagged_complement_alias && kind != carry_complement_flagged_alias) begin
            new_flags = issue_i.flags;
        end
    end

    always_comb begin
        next_state = state;
        next_state.res.valid = issue_i.valid && kind != op_none && !flush_i;
        // A flush kills the op the same way whatever its data or flags.
        next_state.res.undefined = issue_i.valid && !flush_i && undef;
        next_state.res.dst = dst;
        next_state.res.value = undef ? '0 : result;
        next_state.res.flags_we = next_state.res.valid && !undef
                                  && (kind == flagged_complement_alias
                                  || kind == carry_complement_flagged_alias);
        next_state.res.flags = new_flags;
        next_state.kind = issue_i.valid ? kind : op_none;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign result_o = state.res;
    assign kind_o = state.kind;

endmodule : negate_invert_unit

/* File: bench/negate_invert_unit_chk.sv */
/*
 * Port checker for the negate/invert unit.
 * Assumes it is bound to the unit and shares its clock and reset.
 */
`timescale 1ns/1ps
module negate_invert_unit_chk
    import negate_invert_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire issue_t issue_i,
    input wire logic flush_i,
    input wire result_t result_o,
    input wire alias_kind_t kind_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic go;
    logic z1;
    logic inv;
    logic negate_go;
    assign go = issue_i.valid && !flush_i;
    assign z1 = issue_i.insn[9:5] == ZERO_REG_IDX;
    assign inv = go && z1 && issue_i.insn[30:24] == OPC_OR_NOT && issue_i.insn[21];
    assign negate_go = go && z1 && issue_i.insn[30:24] == OPC_SUB && !issue_i.insn[21];
    chk_fixed_latency: assert property (inv |=> result_o.valid)
        else $error("invert result missing");
    chk_invert_kind: assert property (inv |=> kind_o == bitwise_invert_alias)
        else $error("invert kind wrong");
    chk_invert_value: assert property (
        inv && issue_i.insn[31] && issue_i.insn[15:10] == 6'h00
        |=> result_o.value == ~$past(issue_i.second_src_value))
        else $error("invert value wrong");
    chk_narrow_zext: assert property (
        inv && !issue_i.insn[31] |=> result_o.value[63:32] == 32'h0)
        else $error("narrow result not zero extended");
    chk_negate_flags: assert property (
        negate_go && issue_i.insn[31] && issue_i.insn[23:22] != 2'h3
        |=> !result_o.flags_we && result_o.flags == $past(issue_i.flags))
        else $error("negate touched flags");
    chk_negate_reserved: assert property (
        negate_go && issue_i.insn[23:22] == 2'h3 |=> result_o.undefined)
        else $error("reserved shift accepted");
    chk_narrow_amount: assert property (
        inv && !issue_i.insn[31] && issue_i.insn[15]
        |=> result_o.undefined && result_o.valid)
        else $error("narrow amount not undefined");
    chk_flush_kill: assert property (flush_i |=> !result_o.valid)
        else $error("flushed op produced result");
    chk_dst_compare: assert property (
        go && z1 && issue_i.insn[30:24] == OPC_SUB_FLAGGED
        && issue_i.insn[4:0] == ZERO_REG_IDX |=> kind_o == op_none && !result_o.valid)
        else $error("compare decoded as negate");
    chk_src_nonzero: assert property (
        issue_i.insn[9:5] != ZERO_REG_IDX |=> !result_o.valid)
        else $error("alias taken with live first source");
    chk_idle_quiet: assert property (
        !issue_i.valid |=> !result_o.valid && !result_o.flags_we)
        else $error("idle cycle produced a result");
endmodule : negate_invert_unit_chk

bind negate_invert_unit negate_invert_unit_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .issue_i(issue_i), .flush_i(flush_i), .result_o(result_o), .kind_o(kind_o));

/* File: bench/negate_invert_unit_bench.sv */
/*
 * Self-checking bench for the negate/invert unit: issues alias encodings
 * back to back and compares each result one cycle later.
 * Assumes the package constants and a single clock domain.
 */
`timescale 1ns/1ps
module negate_invert_unit_bench
    import negate_invert_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic flush_i = 1'b0;
    issue_t issue_i = '0;
    result_t result_o;
    alias_kind_t kind_o;
    int errors = 0;
    int n_tests = 0;
    logic [63:0] vals [4] = '{64'h8000_0000_0000_0000, 64'h0, 64'hF0F0_1234_8765_9ABC,
        64'h0000_0000_8000_0000};
    logic [5:0] amts [3] = '{6'h00, 6'h1F, 6'h3F};

    always #5 clk_i = ~clk_i;

    negate_invert_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i),
        .flush_i(flush_i), .result_o(result_o), .kind_o(kind_o));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] mk(int k, logic w, logic [1:0] sh, logic [5:0] a,
        logic [4:0] src1, logic [4:0] rd);
        logic [6:0] oc [6] = '{7'h00, OPC_OR_NOT, OPC_SUB, OPC_SUB_FLAGGED, OPC_BORROW,
            OPC_BORROW_FLAGGED};
        return {w, oc[k], k < 4 ? sh : 2'h0, k == 1, 5'h0A, k < 4 ? a : 6'h00, src1, rd};
    endfunction : mk

    // Independent shifter so a shared bug cannot hide; masks to the width.
    function automatic logic [63:0] shf(logic [63:0] v, logic [1:0] t, int a, logic w);
        logic [63:0] m;
        m = w ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
        v = v & m;
        case (t)
            2'h0: return (v << a) & m;
            2'h1: return v >> a;
            2'h2: return w ? 64'($signed(v) >>> a) : {32'h0, 32'($signed(v[31:0]) >>> a)};
            default: return ((v >> a) | (v << ((w ? 64 : 32) - a))) & m;
        endcase
    endfunction : shf

    task automatic send(input logic [31:0] ins, input logic [63:0] src, input cond_flags_t f,
        input alias_kind_t k, input logic fl);
        logic w, und, fs, cy, n, z, c, v;
        logic [63:0] m, op, res;
        logic [64:0] sum;
        w = ins[31];
        m = w ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
        cy = k >= carry_complement_alias;
        fs = k inside {flagged_complement_alias, carry_complement_flagged_alias};
        und = !cy && ((!w && ins[15]) || (k != bitwise_invert_alias && ins[23:22] == 2'h3));
        op = cy ? src & m : shf(src, ins[23:22], ins[15:10], w);
        sum = {1'b0, ~op & m} + (cy ? 65'(f.c) : 65'h1);
        res = (k == bitwise_invert_alias) ? ~op & m : sum[63:0] & m;
        n = w ? res[63] : res[31];
        z = res == 64'h0;
        c = w ? sum[64] : sum[32];
        v = (w ? op[63] : op[31]) && n;
        issue_i = {1'b1, ins, src, f};
        flush_i = fl;
        @(negedge clk_i);
        chk(result_o.valid, 64'(k != op_none && !fl), "valid");
        if (fl) chk(result_o.undefined, 64'h0, "flush undefined");
        if (!fl) chk(kind_o, k, "kind");
        if (k != op_none && !fl) begin
            chk(result_o.undefined, und, "undefined");
            chk(result_o.value, und ? 64'h0 : res, "value");
            chk(result_o.dst, ins[4:0], "dst");
            chk(result_o.flags_we, fs && !und, "flag write");
            if (!und) chk(result_o.flags, fs ? {n, z, c, v} : f, "flags");
        end
    endtask : send

    initial begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        // Every kind, width, shift code, amount boundary, data edge and flag mix.
        for (int k = 1; k < 6; k++) begin
            for (int i = 0; i < 96; i++) begin
                send(mk(k, i[0], i[2:1], amts[(i / 8) % 3], 5'h1F, 5'(i % 31)), vals[i / 24],
                    4'(i), alias_kind_t'(k), 1'b0);
            end
        end
        send(mk(3, 1'b1, 2'h0, 6'h00, 5'h1F, 5'h1F), vals[2], 4'h0, op_none, 1'b0);
        send(mk(2, 1'b1, 2'h0, 6'h00, 5'h04, 5'h01), vals[2], 4'h0, op_none, 1'b0);
        send(mk(1, 1'b0, 2'h0, 6'h00, 5'h1F, 5'h01), vals[2], 4'hF, op_none, 1'b1);
        send(mk(4, 1'b1, 2'h0, 6'h00, 5'h1F, 5'h02), vals[0], 4'h2, carry_complement_alias,
            1'b0);
        // A flag-setting negate word with valid low must leave no trace.
        issue_i.insn = mk(3, 1'b1, 2'h0, 6'h00, 5'h1F, 5'h02);
        issue_i.valid = 1'b0;
        @(negedge clk_i);
        chk(result_o.valid, 64'h0, "idle valid");
        chk(kind_o, op_none, "idle kind");
        chk(result_o.flags_we, 64'h0, "idle flag write");
        wrap_up();
    end
endmodule : negate_invert_unit_bench
